// ### core/npl_slave.sv
`timescale 1ns/100ps
`include "npl_consts.svh"
// Operation
// - 16-bit byte port: select 1 for bits 15..8, select 0 for 7..0, halfword address.
// - Big-endian puts even bytes on upper lane; little-endian puts them on lower.
// - 8-bit port carries bytes on bits 7..0, one select, byte address.
// - 8-bit and halfword-granular ports need no lane swap for either endianness.
// - Basic scheme drives acknowledge combinationally, one clock per transfer.
// - Registered scheme acknowledges the clock after request, then drops; two clocks each.
// - Advanced scheme holds acknowledge while the next clock is known to address us and, for a write, two buffer slots are free.
// - Advanced zero-wait burst of N transfers finishes in N plus one clocks.
// - Advanced single transfer behaves like registered: one wait state, two clocks.
// - Cycle type tag: 000 classic, 010 incrementing burst, 111 end of burst.
// - A transfer ends only when acknowledge and strobe are both high.
// - Unsupported cycle types complete as classic, without acknowledge held ahead.

module npl_slave #(
	parameter int AW = `NPL_ADR_W,
	parameter int DW = `NPL_DAT_W,
	parameter int GRAN = `NPL_GRAN_W,
	parameter bit BIG = 1'b1,
	parameter npl_pkg::npl_term_t TERM = npl_pkg::term_adv,
	parameter int DEPTH = `NPL_FIFO_DEPTH
) (
	input wire logic clk, // Bus clock, 250 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire logic cyc_i, // Bus cycle in progress
	input wire logic stb_i, // Transfer strobe
	input wire logic we_i, // Write when high
	input wire logic [AW-1:0] adr_i, // Address
	input wire logic [DW-1:0] dat_i, // Write data
	input wire logic [DW/GRAN-1:0] sel_i, // Lane selects
	input wire logic [`NPL_CTI_W-1:0] cti_i, // Cycle type tag
	output logic [DW-1:0] dat_o, // Read data
	output logic ack_o, // Transfer acknowledge
	output logic wr_valid, // Buffered write available
	input wire logic wr_ready, // Consumer takes buffered write
	output logic [AW-1:0] wr_addr, // Address of lane 0 of the write
	output logic [DW-1:0] wr_data, // Write data in address order
	output logic [DW/GRAN-1:0] wr_sel, // Selects in address order
	input wire logic [DW-1:0] rd_data, // Read data for adr_i, address order
	output logic rd_done // Pulse: a read terminated last clock
);
	localparam int NS = DW / GRAN;
	localparam int ADR_LSB = $clog2(NS);
	localparam int FW = AW + DW + NS;
	localparam int CW = $clog2(DEPTH) + 1;

	initial begin
		if (!((DW == 16 && (GRAN == 8 || GRAN == 16)) || (DW == 8 && GRAN == 8))) begin
			$error("npl_slave: only 8-bit and 16-bit narrow ports are served");
		end
		if (DEPTH < 2) begin
			$error("npl_slave: buffer must hold at least two writes");
		end
	end

	npl_pkg::npl_ack_state_t state_reg;
	npl_pkg::npl_ack_state_t state_next;
	logic [DW-1:0] dat_o_reg;
	logic rd_done_reg;
	logic req;
	logic room1;
	logic room2;
	logic burst_ok;
	logic ack_int;
	logic term;
	logic push;
	logic fifo_in_ready;
	logic [CW-1:0] fifo_count;
	logic [AW-1:0] addr_norm;
	logic [DW-1:0] ord_dat;
	logic [NS-1:0] ord_sel;
	logic [DW-1:0] bus_rd;
	logic [FW-1:0] fifo_in;
	logic [FW-1:0] fifo_out;

	npl_lane_map #(
		.DW(DW),
		.NS(NS),
		.BIG(BIG)
	) u_map (
		.bus_dat(dat_i),
		.bus_sel(sel_i),
		.ord_rd(rd_data),
		.ord_dat(ord_dat),
		.ord_sel(ord_sel),
		.bus_rd(bus_rd)
	);

	// Low address bits below the select granule are not part of the address
	generate
		if (ADR_LSB > 0) begin : g_adr_mask
			assign addr_norm = {adr_i[AW-1:ADR_LSB], {ADR_LSB{1'b0}}};
		end else begin : g_adr_full
			assign addr_norm = adr_i;
		end
	endgenerate

	assign req = cyc_i & stb_i;
	assign room1 = ~we_i | fifo_in_ready;
	// Holding acknowledge commits the next beat too, so a write needs two free slots
	assign room2 = ~we_i | (fifo_count <= CW'(DEPTH - 2));
	assign burst_ok = (cti_i == `NPL_CTI_INCR);

	always_comb begin
		state_next = npl_pkg::st_idle;
		case (state_reg)
			npl_pkg::st_idle: begin
				if (req && room1) begin
					state_next = npl_pkg::st_single;
				end
			end
			npl_pkg::st_single, npl_pkg::st_burst: begin
				if (TERM == npl_pkg::term_adv && req && burst_ok && room2) begin
					state_next = npl_pkg::st_burst;
				end else begin
					state_next = npl_pkg::st_idle;
				end
			end
			default: begin
				state_next = npl_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn || TERM == npl_pkg::term_async) begin
			state_reg <= npl_pkg::st_idle;
		end else begin
			state_reg <= state_next;
		end
	end

	// Read data is captured on the clock that raises or keeps acknowledge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dat_o_reg <= '0;
		end else if (state_next != npl_pkg::st_idle) begin
			dat_o_reg <= bus_rd;
		end
	end

	assign ack_int = (TERM == npl_pkg::term_async) ? (req & room1)
		: (state_reg != npl_pkg::st_idle);
	assign ack_o = ack_int;
	// Held bursts present the current beat's data; the register only serves the first beat
	assign dat_o = (TERM == npl_pkg::term_async || state_reg == npl_pkg::st_burst) ? bus_rd
		: dat_o_reg;
	assign term = ack_int & req;
	assign push = term & we_i;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_done_reg <= `NPL_RD_DONE_RST;
		end else begin
			rd_done_reg <= term & ~we_i;
		end
	end
	assign rd_done = rd_done_reg;

	assign fifo_in = {addr_norm, ord_dat, ord_sel};

	npl_fifo #(
		.W(FW),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(fifo_out),
		.count(fifo_count)
	);

	assign wr_addr = fifo_out[FW-1 -: AW];
	assign wr_data = fifo_out[NS +: DW];
	assign wr_sel = fifo_out[NS-1:0];

	async_ack_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM == npl_pkg::term_async && req && room1) |-> ack_o)
		else $error("async ack missing in request clock");

	reg_ack_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM == npl_pkg::term_reg && ack_o) |=> !ack_o)
		else $error("registered ack held two clocks");

	reg_ack_wait_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM != npl_pkg::term_async && !ack_o && req && room1) |=> ack_o)
		else $error("ack not raised one clock after request");

	ack_cause_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM != npl_pkg::term_async && $rose(ack_o)) |-> $past(req))
		else $error("ack raised without a request");

	burst_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM == npl_pkg::term_adv && ack_o && req && burst_ok && room2) |=> ack_o)
		else $error("ack dropped inside a known burst");

	classic_drop_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM != npl_pkg::term_async && ack_o && cti_i != `NPL_CTI_INCR) |=> !ack_o)
		else $error("ack held ahead for non-burst cycle");

	burst_four_a: assert property (@(posedge clk) disable iff (!resetn)
		(TERM == npl_pkg::term_adv && !ack_o && req && room2 && !we_i && burst_ok)
		##1 (req && burst_ok) [*3] |-> ($past(ack_o, 2) && $past(ack_o) && ack_o))
		else $error("burst beats not back to back");

	push_safe_a: assert property (@(posedge clk) disable iff (!resetn)
		push |-> (fifo_in_ready && stb_i && cyc_i))
		else $error("write taken without strobe or room");

	lane_swap_a: assert property (@(posedge clk) disable iff (!resetn)
		(push && NS == 2 && BIG) |-> (fifo_in[NS +: 8] == dat_i[15:8] && fifo_in[1] == sel_i[0]))
		else $error("big-endian lane mapping wrong");

	read_done_a: assert property (@(posedge clk) disable iff (!resetn)
		(ack_o && !stb_i) |=> !rd_done)
		else $error("read counted without strobe");

endmodule

// ### core/npl_consts.svh
`ifndef NPL_CONSTS_SVH
`define NPL_CONSTS_SVH

// Cycle type tag codes
`define NPL_CTI_W 3
`define NPL_CTI_CLASSIC 3'h0
`define NPL_CTI_INCR 3'h2
`define NPL_CTI_END 3'h7

// Port geometry and buffer defaults
`define NPL_ADR_W 64
`define NPL_DAT_W 16
`define NPL_GRAN_W 8
`define NPL_FIFO_DEPTH 8

// Reset values
`define NPL_ACK_RST 1'b0
`define NPL_RD_DONE_RST 1'b0

`endif

// ### core/npl_pkg.sv
package npl_pkg;

	// Cycle termination scheme
	typedef enum {term_async, term_reg, term_adv} npl_term_t;

	// Acknowledge sequencer
	typedef enum logic [1:0] {st_idle, st_single, st_burst} npl_ack_state_t;

endpackage

// ### core/npl_lane_map.sv
`timescale 1ns/100ps

// Moves select lanes between bus order and address order (lane 0 = lowest address)
module npl_lane_map #(
	parameter int DW = 16,
	parameter int NS = 2,
	parameter bit BIG = 1'b1
) (
	input wire logic [DW-1:0] bus_dat, // Data in bus lane order
	input wire logic [NS-1:0] bus_sel, // Selects in bus lane order
	input wire logic [DW-1:0] ord_rd, // Read data in address order
	output logic [DW-1:0] ord_dat, // Data in address order
	output logic [NS-1:0] ord_sel, // Selects in address order
	output logic [DW-1:0] bus_rd // Read data in bus lane order
);
	localparam int LW = DW / NS;

	initial begin
		if (NS < 1 || DW % NS != 0) begin
			$error("npl_lane_map: lane count must divide the data width");
		end
	end

	// A single lane never swaps, so endianness only matters when NS is above one
	genvar i;
	generate
		for (i = 0; i < NS; i++) begin : g_lane
			localparam int J = BIG ? (NS - 1 - i) : i;
			assign ord_dat[i*LW +: LW] = bus_dat[J*LW +: LW];
			assign ord_sel[i] = bus_sel[J];
			assign bus_rd[J*LW +: LW] = ord_rd[i*LW +: LW];
		end
	endgenerate

endmodule

// ### core/npl_fifo.sv
`timescale 1ns/100ps

module npl_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // Bus clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic in_valid, // Push request
	output logic in_ready, // Room for one word
	input wire logic [W-1:0] in_data, // Word pushed
	output logic out_valid, // Word available
	input wire logic out_ready, // Consumer takes word
	output logic [W-1:0] out_data, // Oldest word
	output logic [$clog2(DEPTH):0] count // Words held
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [PW:0] wptr_reg;
	logic [PW:0] rptr_reg;
	logic push;
	logic pop;

	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH) begin
			$error("npl_fifo: depth must be a power of two, at least 2");
		end
	end

	assign count = wptr_reg - rptr_reg;
	assign in_ready = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rptr_reg[PW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_reg[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wptr_reg <= '0;
		end else if (push) begin
			wptr_reg <= wptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rptr_reg <= '0;
		end else if (pop) begin
			rptr_reg <= rptr_reg + 1'b1;
		end
	end

endmodule

// ### tb/npl_master.sv
`timescale 1ns/100ps

module npl_master (
	input wire logic clk, // Bus clock
	input wire logic ack, // Acknowledge from slave
	output logic cyc, // Cycle
	output logic stb, // Strobe
	output logic we, // Write
	output logic [63:0] adr, // Address
	output logic [15:0] dat, // Write data, bus order
	output logic [1:0] sel, // Selects
	output logic [2:0] cti // Cycle type
);
	initial begin
		{cyc, stb, we, adr, dat, sel, cti} = '0;
	end
	// Burst of n beats; clks counts clocks from request to last acknowledge
	task automatic run(input int n, input logic w, input logic [2:0] ct, input logic [63:0] a,
		input logic [15:0] d, input logic [1:0] s, output int clks);
		int i;
		clks = 0;
		for (i = 0; i < n; i++) begin
			cyc = 1'b1;
			stb = 1'b1;
			we = w;
			adr = a + 64'(2 * i);
			dat = d + 16'(i);
			sel = s;
			cti = (ct == 3'h2 && i == n - 1) ? 3'h7 : ct;
			clks++;
			@(posedge clk);
			while (ack !== 1'b1) begin
				clks++;
				@(posedge clk);
			end
			#1;
		end
		stb = 1'b0;
		cyc = 1'b0;
		dat = ~dat;
		adr = ~adr;
		cti = 3'h0;
		@(posedge clk);
		#1;
	endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic rdy = 1'b1;
	logic rnd = 1'b0;
	logic cyc, stb, we, ack, wv, rdone, prev_rd = 1'b0;
	logic [63:0] adr, waddr;
	logic [15:0] dat, dato, wdat, rdat;
	logic [1:0] sel, wsel;
	logic [2:0] cti;
	logic [81:0] q[$];
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	int c;
	npl_master m (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(dat),
		.sel(sel), .cti(cti));
	npl_slave uut (.clk(clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .dat_i(dat), .sel_i(sel), .cti_i(cti), .dat_o(dato), .ack_o(ack),
		.wr_valid(wv), .wr_ready(rdy), .wr_addr(waddr), .wr_data(wdat), .wr_sel(wsel),
		.rd_data(rdat), .rd_done(rdone));
	assign rdat = adr[15:0] ^ 16'ha5c3;
	function automatic logic [15:0] swp(input logic [15:0] v);
		return {v[7:0], v[15:8]};
	endfunction
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles > 4000) begin
			n_fail++;
			summarize();
		end
		#1;
		if (rnd) begin
			rdy = 1'($urandom);
		end
	end
	always @(negedge clk) begin
		`CHK(rdone, prev_rd)
		prev_rd = cyc & stb & ack & ~we;
		if (prev_rd) begin
			`CHK(dato, swp(adr[15:0] ^ 16'ha5c3))
		end
		if (wv === 1'b1 && rdy) begin
			`CHK({waddr, wdat, wsel}, q.pop_front())
		end
	end
	task automatic go(input int n, input logic w, input logic [2:0] ct, input int exp);
		logic [63:0] a;
		logic [15:0] d;
		logic [1:0] s;
		a = {48'h0, 16'($urandom)} & ~64'h1;
		d = 16'($urandom);
		s = 2'($urandom);
		for (int i = 0; i < n && w; i++) begin
			q.push_back({a + 64'(2 * i), swp(d + 16'(i)), s[0], s[1]});
		end
		m.run(n, w, ct, a, d, s, c);
		if (exp > 0) begin
			`CHK(c, exp)
		end
	endtask
	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'h4bfb));
		repeat (8) @(posedge clk);
		#1;
		resetn = 1'b1;
		@(posedge clk);
		#1;
		go(1, 1'b1, 3'h0, 2);
		go(8, 1'b1, 3'h2, 9);
		go(16, 1'b0, 3'h2, 17);
		go(2, 1'b1, 3'h2, 3);
		go(4, 1'b1, 3'h1, 8);
		go(3, 1'b0, 3'h0, 6);
		rnd = 1'b1;
		repeat (6) go(1 + $urandom % 4, 1'($urandom), 3'h2, 0);
		rnd = 1'b0;
		@(posedge clk);
		#1;
		rdy = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		rdy = 1'b0;
		repeat (8) go(1, 1'b1, 3'h0, 2);
		fork
			go(1, 1'b1, 3'h0, 0);
			begin
				repeat (10) @(posedge clk);
				#1;
				`CHK(ack, 1'b0)
				rdy = 1'b1;
			end
		join
		repeat (20) @(posedge clk);
		`CHK(q.size(), 0)
		summarize();
	end
endmodule
